// ---- hfpa_defines.svh ----
// Address map, field positions and reset values of the host FIFO port block
// How it works
// - Writes to read-only registers are ignored; contents stay unchanged.
// - Reads of write-only registers always return zero.
// - Write-one-to-clear bits read back; writing one clears, zero leaves alone.
// - Read-to-clear bits are cleared by the host reading them.
// - Latching bits hold their latched state until the register is read.
// - Bits kept across soft reset keep their value when soft reset occurs.
// - Hard reset loads every internal register but queue storage with its default value; soft reset spares the keep field.
// - Four host queues: receive status, receive data, transmit status, transmit data.
// - Both receive queues are read-only; host writes to them do nothing.
// - Reading receive status pop port returns oldest entry and removes it.
// - Reading receive status peek port returns oldest entry, keeps it queued.
// - Receive data port reads of a non-empty queue return the oldest word; a DWORD read or a 16-bit high half removes it; an empty one reads zero.
// - Receive data port aliased over 8 DWORDs, or 16 in 16-bit mode.
// - Reading transmit status pop port returns oldest entry and removes it.
// - Reading transmit status peek port returns oldest entry, keeps it queued.
// - Transmit data port is write-only; reads never disturb its queue.
// - Transmit data port aliased over 8 DWORDs, or 16 in 16-bit mode.
`ifndef HFPA_DEFINES_SVH
`define HFPA_DEFINES_SVH

// DWORD indices (byte address bits 7:2)
`define HFPA_IDX_RXD 6'h00
`define HFPA_IDX_TXD 6'h10
`define HFPA_IDX_RXS_POP 6'h20
`define HFPA_IDX_RXS_PEEK 6'h21
`define HFPA_IDX_TXS_POP 6'h22
`define HFPA_IDX_TXS_PEEK 6'h23
`define HFPA_IDX_EVT 6'h24
`define HFPA_IDX_CTRL 6'h25
`define HFPA_IDX_CMD 6'h26
`define HFPA_IDX_LVL 6'h27
`define HFPA_ALIAS32 6'h08
`define HFPA_ALIAS16 6'h10

// Queue numbers
`define HFPA_Q_RXS 2'h0
`define HFPA_Q_RXD 2'h1
`define HFPA_Q_TXS 2'h2
`define HFPA_Q_TXD 2'h3

// Event register bits
`define HFPA_EVT_RXS_OVF 0
`define HFPA_EVT_RXD_OVF 1
`define HFPA_EVT_RXD_UND 2
`define HFPA_EVT_LINK_LL 3
`define HFPA_EVT_TXERR_LH 4

// Control register fields
`define HFPA_CTRL_TXEN 0
`define HFPA_CTRL_KEEP_LSB 8
`define HFPA_CTRL_KEEP_MSB 15

// Command register bits
`define HFPA_CMD_RX_FLUSH 0
`define HFPA_CMD_TX_FLUSH 1

`define HFPA_ZERO32 32'h0000_0000
`define HFPA_KEEP_RST 8'h00

`endif

// ---- hfpa_fifo_ports.sv ----
// Host access to the four packet queues and the block's attribute registers
`timescale 1ns/1ps
`include "hfpa_defines.svh"

module hfpa_fifo_ports #(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic soft_rst_i,
  input wire logic mode16_i,
  input wire hfpa_pkg::hfpa_hreq_t hreq_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire hfpa_pkg::hfpa_qwr_t rxs_in_i,
  input wire hfpa_pkg::hfpa_qwr_t rxd_in_i,
  input wire hfpa_pkg::hfpa_qwr_t txs_in_i,
  input wire logic txd_pop_i,
  output logic [31:0] txd_data_o,
  output logic txd_valid_o,
  input wire logic link_up_i,
  input wire logic tx_err_i,
  output logic tx_enable_o
);
  import hfpa_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so only a power-of-two depth works
  if (DEPTH < 2 || DEPTH > 64 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two from 2 to 64");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic hfpa_port_t port_of(input logic [7:0] a, input logic m16);
    logic [5:0] idx;
    logic [5:0] span;
    hfpa_port_t p;
    idx = a[7:2];
    span = m16 ? `HFPA_ALIAS16 : `HFPA_ALIAS32;
    p = HFPA_P_NONE;
    if (idx >= `HFPA_IDX_RXD && idx < `HFPA_IDX_RXD + span) begin
      p = HFPA_P_RXD;
    end else if (idx >= `HFPA_IDX_TXD && idx < `HFPA_IDX_TXD + span) begin
      p = HFPA_P_TXD;
    end else if (idx == `HFPA_IDX_RXS_POP) begin
      p = HFPA_P_RXS_POP;
    end else if (idx == `HFPA_IDX_RXS_PEEK) begin
      p = HFPA_P_RXS_PEEK;
    end else if (idx == `HFPA_IDX_TXS_POP) begin
      p = HFPA_P_TXS_POP;
    end else if (idx == `HFPA_IDX_TXS_PEEK) begin
      p = HFPA_P_TXS_PEEK;
    end else if (idx == `HFPA_IDX_EVT) begin
      p = HFPA_P_EVT;
    end else if (idx == `HFPA_IDX_CTRL) begin
      p = HFPA_P_CTRL;
    end else if (idx == `HFPA_IDX_CMD) begin
      p = HFPA_P_CMD;
    end else if (idx == `HFPA_IDX_LVL) begin
      p = HFPA_P_LVL;
    end
    return p;
  endfunction

  // True on a whole DWORD access, or on the high half in 16-bit mode
  function automatic logic last_half(input logic [7:0] a, input logic m16);
    return !m16 || a[1];
  endfunction

  hfpa_port_t port;
  logic rd_done;
  logic wr_done;
  logic [31:0] wword;
  logic [15:0] whold_r;
  logic [15:0] rhold_r;

  assign port = port_of(hreq_i.addr, mode16_i);
  // side effects only on the second halfword
  assign rd_done = hreq_i.rd && last_half(hreq_i.addr, mode16_i);
  assign wr_done = hreq_i.wr && last_half(hreq_i.addr, mode16_i);
  assign wword = mode16_i ? {hreq_i.wdata[15:0], whold_r} : hreq_i.wdata;

  // low halfword held until the high half arrives
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst_i) begin
      whold_r <= 16'h0000;
    end else if (hreq_i.wr && mode16_i && !hreq_i.addr[1]) begin
      whold_r <= hreq_i.wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queues

  logic [31:0] mem_r [4][DEPTH];
  logic [AW-1:0] wp_r [4];
  logic [AW-1:0] rp_r [4];
  logic [AW:0] cnt_r [4];
  logic [3:0] push;
  logic [3:0] pop;
  logic [3:0] flush;
  logic [31:0] push_data [4];
  logic [31:0] head [4];
  logic [3:0] empty;
  logic [3:0] full;
  logic [31:0] ctrl_r;
  logic [7:0] keep_r;

  always_comb begin
    for (int q = 0; q < 4; q++) begin
      head[q] = mem_r[q][rp_r[q]];
      empty[q] = (cnt_r[q] == '0);
      // A full queue drops the push; for the two receive queues an overflow flag keeps the loss visible
      full[q] = (cnt_r[q] == (AW+1)'(DEPTH));
    end
  end

  always_comb begin
    push_data[`HFPA_Q_RXS] = rxs_in_i.data;
    push_data[`HFPA_Q_RXD] = rxd_in_i.data;
    push_data[`HFPA_Q_TXS] = txs_in_i.data;
    push_data[`HFPA_Q_TXD] = wword;
    // four queues fed from link side and host
    // receive queues written by the link only
    push[`HFPA_Q_RXS] = rxs_in_i.push && !full[`HFPA_Q_RXS];
    push[`HFPA_Q_RXD] = rxd_in_i.push && !full[`HFPA_Q_RXD];
    push[`HFPA_Q_TXS] = txs_in_i.push && !full[`HFPA_Q_TXS];
    // any alias write enters transmit data queue
    push[`HFPA_Q_TXD] = wr_done && port == HFPA_P_TXD && !full[`HFPA_Q_TXD];
    pop[`HFPA_Q_RXS] = rd_done && port == HFPA_P_RXS_POP && !empty[`HFPA_Q_RXS];
    pop[`HFPA_Q_RXD] = rd_done && port == HFPA_P_RXD && !empty[`HFPA_Q_RXD];
    pop[`HFPA_Q_TXS] = rd_done && port == HFPA_P_TXS_POP && !empty[`HFPA_Q_TXS];
    // only the link drains transmit data
    pop[`HFPA_Q_TXD] = txd_pop_i && ctrl_r[`HFPA_CTRL_TXEN] && !empty[`HFPA_Q_TXD];
    // A flush empties a queue at once; words the link has not taken are lost
    flush = 4'h0;
    if (wr_done && port == HFPA_P_CMD) begin
      flush[`HFPA_Q_RXS] = wword[`HFPA_CMD_RX_FLUSH];
      flush[`HFPA_Q_RXD] = wword[`HFPA_CMD_RX_FLUSH];
      flush[`HFPA_Q_TXD] = wword[`HFPA_CMD_TX_FLUSH];
    end
  end

  // Storage needs no reset; pointers decide what is valid
  always_ff @(posedge clk_i) begin
    for (int q = 0; q < 4; q++) begin
      if (push[q]) begin
        mem_r[q][wp_r[q]] <= push_data[q];
      end
    end
  end

  // pointers to defaults on any reset
  always_ff @(posedge clk_i) begin
    for (int q = 0; q < 4; q++) begin
      if (srst_i || soft_rst_i || flush[q]) begin
        wp_r[q] <= '0;
        rp_r[q] <= '0;
        cnt_r[q] <= '0;
      end else begin
        if (push[q]) begin
          wp_r[q] <= wp_r[q] + AW'(1);
        end
        if (pop[q]) begin
          rp_r[q] <= rp_r[q] + AW'(1);
        end
        if (push[q] && !pop[q]) begin
          cnt_r[q] <= cnt_r[q] + (AW+1)'(1);
        end else if (pop[q] && !push[q]) begin
          cnt_r[q] <= cnt_r[q] - (AW+1)'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst_i) begin
      txd_data_o <= `HFPA_ZERO32;
      txd_valid_o <= 1'b0;
    end else begin
      txd_valid_o <= pop[`HFPA_Q_TXD];
      if (pop[`HFPA_Q_TXD]) begin
        txd_data_o <= head[`HFPA_Q_TXD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attribute registers

  logic [4:0] evt_r;
  logic evt_rd;
  logic evt_wr;

  assign evt_rd = rd_done && port == HFPA_P_EVT;
  assign evt_wr = wr_done && port == HFPA_P_EVT;

  // Overflow flags: a new loss beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst_i) begin
      evt_r <= 5'h00;
    end else begin
      evt_r[`HFPA_EVT_RXS_OVF] <= (rxs_in_i.push && full[`HFPA_Q_RXS])
        || (evt_r[`HFPA_EVT_RXS_OVF] && !(evt_wr && wword[`HFPA_EVT_RXS_OVF]));
      evt_r[`HFPA_EVT_RXD_OVF] <= (rxd_in_i.push && full[`HFPA_Q_RXD])
        || (evt_r[`HFPA_EVT_RXD_OVF] && !(evt_wr && wword[`HFPA_EVT_RXD_OVF]));
      evt_r[`HFPA_EVT_RXD_UND] <= (rd_done && port == HFPA_P_RXD && empty[`HFPA_Q_RXD])
        || (evt_r[`HFPA_EVT_RXD_UND] && !evt_rd);
      // Latch low reads zero after reset until a read loads the link level
      // latch low released by read
      evt_r[`HFPA_EVT_LINK_LL] <= evt_rd ? link_up_i : (evt_r[`HFPA_EVT_LINK_LL] && link_up_i);
      evt_r[`HFPA_EVT_TXERR_LH] <= tx_err_i || (evt_r[`HFPA_EVT_TXERR_LH] && !evt_rd);
    end
  end

  // control to defaults on any reset
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst_i) begin
      ctrl_r <= `HFPA_ZERO32;
    end else if (wr_done && port == HFPA_P_CTRL) begin
      ctrl_r <= wword;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      keep_r <= `HFPA_KEEP_RST;
    end else if (wr_done && port == HFPA_P_CTRL) begin
      keep_r <= wword[`HFPA_CTRL_KEEP_MSB:`HFPA_CTRL_KEEP_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst_i) begin
      tx_enable_o <= 1'b0;
    end else begin
      tx_enable_o <= ctrl_r[`HFPA_CTRL_TXEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rword;

  always_comb begin
    rword = `HFPA_ZERO32;
    case (port)
      HFPA_P_RXD: rword = head[`HFPA_Q_RXD];
      // pop and peek see the same head
      HFPA_P_RXS_POP, HFPA_P_RXS_PEEK: rword = head[`HFPA_Q_RXS];
      // pop and peek see the same head
      HFPA_P_TXS_POP, HFPA_P_TXS_PEEK: rword = head[`HFPA_Q_TXS];
      HFPA_P_EVT: rword = {27'h0000000, evt_r};
      HFPA_P_CTRL: rword = {ctrl_r[31:16], keep_r, ctrl_r[7:0]};
      // Depth is capped at 64, so every count fits its byte
      // level word has no write path
      HFPA_P_LVL: rword = {8'(cnt_r[3]), 8'(cnt_r[2]), 8'(cnt_r[1]), 8'(cnt_r[0])};
      // command and transmit data read zero
      default: rword = `HFPA_ZERO32;
    endcase
    if (empty[`HFPA_Q_RXD] && port == HFPA_P_RXD) begin
      rword = `HFPA_ZERO32;
    end
  end

  // A lone high half replays stale hold data; the host must pair halves
  // High half served from the word captured at the low half
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst_i) begin
      rhold_r <= 16'h0000;
      rdata_o <= `HFPA_ZERO32;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= hreq_i.rd;
      if (hreq_i.rd && mode16_i && !hreq_i.addr[1]) begin
        rhold_r <= rword[31:16];
        rdata_o <= {16'h0000, rword[15:0]};
      end else if (hreq_i.rd && mode16_i) begin
        rdata_o <= {16'h0000, rhold_r};
      end else if (hreq_i.rd) begin
        rdata_o <= rword;
      end
    end
  end

endmodule

// ---- hfpa_fifo_ports_chk.sv ----
// Port checker for the host FIFO port block
`timescale 1ns/1ps
`include "hfpa_defines.svh"
module hfpa_fifo_ports_chk #(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic soft_rst_i,
  input wire logic mode16_i,
  input wire hfpa_pkg::hfpa_hreq_t hreq_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire hfpa_pkg::hfpa_qwr_t rxs_in_i,
  input wire logic txd_pop_i,
  input wire logic txd_valid_o,
  input wire logic tx_enable_o
);
  import hfpa_pkg::*;
  logic [5:0] idx;
  logic peek_rd;
  assign idx = hreq_i.addr[7:2];
  assign peek_rd = hreq_i.rd && idx == `HFPA_IDX_RXS_PEEK && !mode16_i && !soft_rst_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////
  a_read_answer: assert property (
    hreq_i.rd && !soft_rst_i |=> rvalid_o) else $error("read got no answer");
  a_answer_cause: assert property (
    rvalid_o |-> $past(hreq_i.rd)) else $error("answer without read");
  a_wo_reads_zero: assert property (
    hreq_i.rd && idx == `HFPA_IDX_CMD |=> rdata_o == 32'h0) else $error("command read not zero");
  a_txd_read_zero: assert property (
    hreq_i.rd && idx[5:4] == 2'h1 |=> rdata_o == 32'h0) else $error("tx data read not zero");
  a_pop_cause: assert property (
    txd_valid_o |-> $past(txd_pop_i)) else $error("tx word without pop");
  a_soft_reset_idle: assert property (
    soft_rst_i |=> !rvalid_o && !txd_valid_o && !tx_enable_o && rdata_o == 32'h0) else $error("soft reset");
  a_half_upper_zero: assert property (
    hreq_i.rd && mode16_i && !soft_rst_i |=> rdata_o[31:16] == 16'h0) else $error("upper half not zero");
  a_peek_keeps_head: assert property (
    peek_rd && !rxs_in_i.push && !$past(rxs_in_i.push)
    ##1 !hreq_i.wr && !hreq_i.rd && !rxs_in_i.push && !soft_rst_i
    ##1 peek_rd |=> rdata_o == $past(rdata_o, 2)) else $error("peek changed head");
  c_peek: cover property (peek_rd);
  c_tx_word: cover property (txd_valid_o);
  c_half_read: cover property (hreq_i.rd && mode16_i);
endmodule
bind hfpa_fifo_ports hfpa_fifo_ports_chk #(.DEPTH(DEPTH)) i_chk (.clk_i(clk_i), .srst_i(srst_i),
  .soft_rst_i(soft_rst_i), .mode16_i(mode16_i), .hreq_i(hreq_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .rxs_in_i(rxs_in_i), .txd_pop_i(txd_pop_i), .txd_valid_o(txd_valid_o), .tx_enable_o(tx_enable_o));

// ---- hfpa_fifo_ports_test.sv ----
// Self-checking bench for the host FIFO port block
`timescale 1ns/1ps
module hfpa_fifo_ports_test;
  import hfpa_pkg::*;
  localparam int DEPTH = 8;
  logic clk_i = 0, srst_i = 1, soft_rst_i = 0, mode16_i = 0, txd_pop_i = 0, link_up_i = 1, tx_err_i = 0;
  hfpa_hreq_t hreq;
  hfpa_qwr_t qin [3] = '{default: '0};
  logic [31:0] rdata_o, txd_data_o, q;
  logic [31:0] w [8];
  logic rvalid_o, txd_valid_o, tx_enable_o;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #4 clk_i = ~clk_i;
  hfpa_fifo_ports #(.DEPTH(DEPTH)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .soft_rst_i(soft_rst_i),
    .mode16_i(mode16_i), .hreq_i(hreq), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rxs_in_i(qin[0]),
    .rxd_in_i(qin[1]), .txs_in_i(qin[2]), .txd_pop_i(txd_pop_i), .txd_data_o(txd_data_o),
    .txd_valid_o(txd_valid_o), .link_up_i(link_up_i), .tx_err_i(tx_err_i), .tx_enable_o(tx_enable_o));
  hfpa_host_model i_host (.clk_i(clk_i), .rdata_i(rdata_o), .hreq_o(hreq));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lvl(input int txd, input int txs, input int rxd, input int rxs);
    return {8'(txd), 8'(txs), 8'(rxd), 8'(rxs)};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    i_host.op(0, a, '0, q);
    check(q & m, e);
    check(rvalid_o, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.op(1, a, d, q);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_i);
    #1 s = ~s;
    @(posedge clk_i);
    #1 s = ~s;
  endtask
  task automatic push(input int n, input logic [31:0] d);
    @(posedge clk_i);
    #1 qin[n] = '{1'b1, d};
    @(posedge clk_i);
    #1 qin[n].push = 0;
  endtask
  task automatic txpop(input logic [31:0] e);
    pulse(txd_pop_i);
    check(txd_valid_o, 1);
    check(txd_data_o, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    w[0] = $urandom(25141);
    for (int i = 1; i < 8; i++) w[i] = $urandom;
    repeat (20) @(posedge clk_i);
    #1 srst_i = 0;
    for (int i = 0; i < 3; i++) push(0, w[i]);
    rd(8'h84, w[0]);
    rd(8'h84, w[0]);
    rd(8'h80, w[0]);
    rd(8'h80, w[1]);
    foreach (w[i]) push(1, w[i]);
    wr(8'h00, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), w[i]);
    rd(8'h00, 32'h0);
    rd(8'h90, 32'h4, 32'h4);
    rd(8'h90, 32'h0, 32'h4);
    push(2, w[3]);
    push(2, w[4]);
    rd(8'h8c, w[3]);
    rd(8'h88, w[3]);
    rd(8'h8c, w[4]);
    wr(8'h94, 32'h1);
    for (int i = 0; i < 8; i++) wr(8'h40 + 8'(4 * i), w[i]);
    rd(8'h40, 32'h0);
    wr(8'h9c, 32'hffff_ffff);
    rd(8'h9c, lvl(8, 1, 0, 1));
    for (int i = 0; i < 8; i++) txpop(w[i]);
    wr(8'h40, w[7]);
    rd(8'h98, 32'h0);
    wr(8'h98, 32'h3);
    rd(8'h9c, lvl(0, 1, 0, 0));
    for (int i = 0; i < 9; i++) begin
      push(0, w[i % 8]);
      push(1, w[i % 8]);
    end
    rd(8'h90, 32'h3, 32'h3);
    wr(8'h90, 32'h0);
    rd(8'h90, 32'h3, 32'h3);
    wr(8'h90, 32'h1);
    rd(8'h90, 32'h2, 32'h3);
    wr(8'h90, 32'h2);
    rd(8'h90, 32'h0, 32'h3);
    pulse(tx_err_i);
    rd(8'h90, 32'h10, 32'h10);
    rd(8'h90, 32'h0, 32'h10);
    pulse(link_up_i);
    rd(8'h90, 32'h0, 32'h8);
    rd(8'h90, 32'h8, 32'h8);
    wr(8'h94, 32'h0000_a501);
    pulse(soft_rst_i);
    rd(8'h94, 32'h0000_a500);
    rd(8'h9c, 32'h0);
    check(tx_enable_o, 0);
    pulse(srst_i);
    rd(8'h94, 32'h0);
    // Sixteen-bit mode: halves are paired low then high
    mode16_i = 1;
    wr(8'h94, 32'h1);
    wr(8'h96, 32'h0);
    wr(8'h7c, {16'h0, w[5][15:0]});
    wr(8'h7e, {16'h0, w[5][31:16]});
    txpop(w[5]);
    push(1, w[6]);
    rd(8'h38, {16'h0, w[6][15:0]});
    rd(8'h3a, {16'h0, w[6][31:16]});
    rd(8'h3c, 32'h0);
    print_verdict();
  end
endmodule

// ---- hfpa_host_model.sv ----
// Host processor model issuing single cycles on the host bus
`timescale 1ns/1ps
module hfpa_host_model (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  output hfpa_pkg::hfpa_hreq_t hreq_o
);
  import hfpa_pkg::*;
  initial hreq_o = '0;
  ////////////////////////////////////////////////////////////////
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    #1 hreq_o <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_i);
    #1 hreq_o <= '0;
    q = rdata_i;
  endtask
endmodule

// ---- hfpa_pkg.sv ----
// Types shared by the host FIFO port block and its users
package hfpa_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hfpa_hreq_t;

  typedef struct packed {
    logic push;
    logic [31:0] data;
  } hfpa_qwr_t;

  typedef enum {
    HFPA_P_NONE,
    HFPA_P_RXD,
    HFPA_P_TXD,
    HFPA_P_RXS_POP,
    HFPA_P_RXS_PEEK,
    HFPA_P_TXS_POP,
    HFPA_P_TXS_PEEK,
    HFPA_P_EVT,
    HFPA_P_CTRL,
    HFPA_P_CMD,
    HFPA_P_LVL
  } hfpa_port_t;

endpackage
